// file: vxi_irq_pkg.sv
// constants, types and register map of the interrupt signal router
package vxi_irq_pkg;

	localparam int NLEV  = 7;
	localparam int QDEPTH = 8;
	localparam int QCNTW = 4;
	localparam int NLA   = 256;

	// register byte offsets on the bus
	localparam logic [7:0] ADDR_ROUTE  = 8'h00;
	localparam logic [7:0] ADDR_RAWEN  = 8'h04;
	localparam logic [7:0] ADDR_SIGEN  = 8'h08;
	localparam logic [7:0] ADDR_LOCAL  = 8'h0c;
	localparam logic [7:0] ADDR_MIACK  = 8'h10;
	localparam logic [7:0] ADDR_RAWEVT = 8'h14;
	localparam logic [7:0] ADDR_QPOP   = 8'h18;
	localparam logic [7:0] ADDR_LATAB  = 8'h1c;
	localparam logic [7:0] ADDR_STAT   = 8'h20;

	// values after reset
	localparam logic [6:0] RST_ROUTE = 7'h00;
	localparam logic [6:0] RST_RORA  = 7'h00;
	localparam logic [6:0] RST_RAWEN = 7'h00;
	localparam logic [6:0] RST_SIGEN = 7'h00;
	localparam logic [2:0] RST_LATAB = 3'h0;

	// field positions
	localparam int F_RORA    = 8;
	localparam int F_ASSERT  = 8;
	localparam int F_RELEASE = 9;
	localparam int F_ID      = 16;
	localparam int F_MLA     = 8;
	localparam int F_MTYPE   = 9;
	localparam int F_TYPE    = 10;
	localparam int F_TAB     = 8;
	localparam int EVENT_BIT = 15;
	localparam int TAB_DRESP = 0;
	localparam int TAB_DEVT  = 1;
	localparam int TAB_MSG   = 2;

	// event cause codes in the high byte
	localparam logic [7:0] CODE_NOCAUSE = 8'hfd;
	localparam logic [7:0] CODE_REQT    = 8'hfc;
	localparam logic [7:0] CODE_REQF    = 8'hfb;
	localparam logic [7:0] CODE_UNRCMD  = 8'hfa;
	localparam logic [7:0] CODE_SHMEM   = 8'hf9;

	typedef enum logic [2:0] {
		CAUSE_DEVDEP   = 3'h0,
		CAUSE_RESPONSE = 3'h1,
		CAUSE_NOCAUSE  = 3'h2,
		CAUSE_REQT     = 3'h3,
		CAUSE_REQF     = 3'h4,
		CAUSE_UNRCMD   = 3'h5,
		CAUSE_SHMEM    = 3'h6,
		CAUSE_OTHER    = 3'h7
	} cause_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_IACK  = 3'b010,
		ST_ROUTE = 3'b100
	} state_t;

endpackage

// file: signal_queue.sv
// global signal queue: ordered buffer with selective removal
module signal_queue (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        pushValid,
	input  wire logic [15:0] pushData,
	output logic             full,
	output logic             empty,
	input  wire logic        popReq,
	input  wire logic        matchLa,
	input  wire logic        matchType,
	input  wire logic [7:0]  popLa,
	input  wire logic        popType,
	output logic             popFound,
	output logic [15:0]      popData
);

	logic [15:0]                      mem_q [vxi_irq_pkg::QDEPTH];
	logic [vxi_irq_pkg::QCNTW-1:0]    count_q;
	logic [vxi_irq_pkg::QDEPTH-1:0]   hit;
	logic [vxi_irq_pkg::QCNTW-1:0]    selIdx;
	logic                             doPop;
	logic                             doPush;
	logic [vxi_irq_pkg::QCNTW-1:0]    wrIdx;

	assign full  = (count_q == vxi_irq_pkg::QCNTW'(vxi_irq_pkg::QDEPTH));
	assign empty = (count_q == '0);

	// oldest matching entry wins so arrival order is kept
	always_comb begin
		hit    = '0;
		selIdx = '0;
		for (int i = vxi_irq_pkg::QDEPTH - 1; i >= 0; i--) begin
			hit[i] = (vxi_irq_pkg::QCNTW'(i) < count_q)
				&& (!matchLa || mem_q[i][7:0] == popLa)
				&& (!matchType || mem_q[i][vxi_irq_pkg::EVENT_BIT] == popType);
			if (hit[i]) begin
				selIdx = vxi_irq_pkg::QCNTW'(i);
			end
		end
	end

	assign popFound = |hit;
	assign popData  = popFound ? mem_q[selIdx[2:0]] : 16'h0000;
	assign doPop    = popReq && popFound;
	assign doPush   = pushValid && !full;
	assign wrIdx    = doPop ? count_q - 4'h1 : count_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			count_q <= '0;
		end else if (ce) begin
			count_q <= count_q + {3'h0, doPush} - {3'h0, doPop};
		end
	end

	// removal closes the gap by shifting younger entries down
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < vxi_irq_pkg::QDEPTH; i++) begin
				mem_q[i] <= 16'h0000;
			end
		end else if (ce) begin
			for (int i = 0; i < vxi_irq_pkg::QDEPTH - 1; i++) begin
				if (doPop && vxi_irq_pkg::QCNTW'(i) >= selIdx) begin
					mem_q[i] <= mem_q[i+1];
				end
			end
			if (doPush) begin
				mem_q[wrIdx[2:0]] <= pushData;
			end
		end
	end

	AST_NO_PUSH_FULL: assert property (@(posedge clk)
		disable iff (!nrst) (ce && full && !doPop) |=> full)
		else $error("queue left full state without a pop");

endmodule

// file: vxi_interrupt_signal_router.sv
// interrupt acknowledge, routing, signal dispatch and local interrupter
// Operation
// - asserted line gets acknowledge, returns 16-bit word
// - low byte address, high byte cause
// - bit fifteen splits response from event
// - register-based high byte passed undecoded
// - decode no-cause, request true/false, unrecognised, memory
// - per-level choice: signal or raw handler
// - per address and type: dispatch or queue
// - queue pop matches address, type or both
// - raw path gets level and untouched word
// - separate raw and signal level enables
// - local line assert, supply word, release
// - manual acknowledge for levels not auto-handled
// - register-access level disables itself when fired
// - full queue gates signal levels until pop
// - reset routes every level to signals
// - seven levels, each separately routed
//
// The register addresses and the Wishbone slave port were left to the implementer.
module vxi_interrupt_signal_router (
	input  wire logic        clk,
	input  wire logic        ce,
	input  wire logic        nrst,
	input  wire logic        cyc,
	input  wire logic        stb,
	input  wire logic        we,
	input  wire logic [7:0]  adr,
	input  wire logic [3:0]  sel,
	input  wire logic [31:0] datWr,
	output logic      [31:0] datRd,
	output logic             ack,
	input  wire logic [6:0]  irqIn,
	output logic             iackReq,
	output logic      [2:0]  iackLevel,
	input  wire logic        iackDone,
	input  wire logic [15:0] iackData,
	output logic      [6:0]  irqOut,
	input  wire logic        bpIackSeen,
	input  wire logic [2:0]  bpIackLevel,
	output logic             localIdValid,
	output logic      [15:0] localIdOut,
	output logic             rawValid,
	output logic      [2:0]  rawLevel,
	output logic      [15:0] rawStatus,
	output logic             sigValid,
	output logic      [15:0] sigData,
	output logic      [2:0]  sigCause,
	output logic             queueFull,
	output logic             queueEmpty
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	vxi_irq_pkg::state_t state_q;
	logic [6:0]  route_q, rora_q, rawEn_q, sigEn_q;
	logic [2:0]  latab_q [vxi_irq_pkg::NLA];
	logic [2:0]  curLevel_q, manLevel_q, locLevel_q;
	logic        auto_q, manReq_q, manDone_q;
	logic [15:0] capt_q, manStatus_q, locId_q;
	logic        rawNew_q, popFound_q, popDone_q;
	logic [15:0] popData_q;
	logic [6:0]  pend, curBit;
	logic [2:0]  pick;
	logic        wbAcc, wbWr, wbRd, qFull, qEmpty, qPush, qPop;
	logic        qFound, dispatch;
	logic [15:0] qData;
	logic [31:0] wmask, rdMux;
	logic [2:0]  tab;

	function automatic logic [31:0] laneMask(input logic [3:0] s);
		laneMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic logic [6:0] levelBit(input logic [2:0] lev);
		levelBit = (lev == 3'h0) ? 7'h00 : 7'(8'h01 << (lev - 3'h1));
	endfunction

	function automatic vxi_irq_pkg::cause_t causeOf(input logic [15:0] s,
		input logic msg);
		if (!msg) begin
			causeOf = vxi_irq_pkg::CAUSE_DEVDEP;
		end else if (!s[vxi_irq_pkg::EVENT_BIT]) begin
			causeOf = vxi_irq_pkg::CAUSE_RESPONSE;
		end else begin
			case (s[15:8])
				vxi_irq_pkg::CODE_NOCAUSE: causeOf = vxi_irq_pkg::CAUSE_NOCAUSE;
				vxi_irq_pkg::CODE_REQT:    causeOf = vxi_irq_pkg::CAUSE_REQT;
				vxi_irq_pkg::CODE_REQF:    causeOf = vxi_irq_pkg::CAUSE_REQF;
				vxi_irq_pkg::CODE_UNRCMD:  causeOf = vxi_irq_pkg::CAUSE_UNRCMD;
				vxi_irq_pkg::CODE_SHMEM:   causeOf = vxi_irq_pkg::CAUSE_SHMEM;
				default:                   causeOf = vxi_irq_pkg::CAUSE_OTHER;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: data registered at first edge, writes at ack edge

	assign wbAcc = cyc && stb;
	assign wbWr  = wbAcc && we && ack;
	assign wbRd  = wbAcc && !we && ack;
	assign wmask = laneMask(sel);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ack <= 1'b0;
		end else if (ce) begin
			ack <= wbAcc && !ack;
		end
	end

	always_comb begin
		rdMux = 32'h00000000;
		case (adr)
			vxi_irq_pkg::ADDR_ROUTE:  rdMux = {17'h0, rora_q, 1'b0, route_q};
			vxi_irq_pkg::ADDR_RAWEN:  rdMux = {25'h0, rawEn_q};
			vxi_irq_pkg::ADDR_SIGEN:  rdMux = {25'h0, sigEn_q};
			vxi_irq_pkg::ADDR_LOCAL:  rdMux = {locId_q, 6'h0, irqOut,
				locLevel_q};
			vxi_irq_pkg::ADDR_MIACK:  rdMux = {manStatus_q, 9'h0, manLevel_q,
				2'h0, manReq_q, manDone_q};
			vxi_irq_pkg::ADDR_RAWEVT: rdMux = {rawStatus, 7'h0, rawNew_q,
				5'h0, rawLevel};
			vxi_irq_pkg::ADDR_QPOP:   rdMux = {popData_q, 14'h0, popDone_q,
				popFound_q};
			vxi_irq_pkg::ADDR_LATAB:  rdMux = {21'h0, latab_q[adr], 8'h0};
			vxi_irq_pkg::ADDR_STAT:   rdMux = {24'h0, 5'h0, state_q == 
				vxi_irq_pkg::ST_IDLE, qEmpty, qFull};
			default:                  rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			datRd <= 32'h00000000;
		end else if (ce && wbAcc && !ack) begin
			datRd <= rdMux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// routing and enable state

	always_ff @(posedge clk) begin
		if (!nrst) begin
			route_q <= vxi_irq_pkg::RST_ROUTE;
			rora_q  <= vxi_irq_pkg::RST_RORA;
		end else if (ce && wbWr && adr == vxi_irq_pkg::ADDR_ROUTE) begin
			route_q <= (route_q & ~wmask[6:0]) | (datWr[6:0] & wmask[6:0]);
			rora_q  <= (rora_q & ~wmask[14:8]) | (datWr[14:8] & wmask[14:8]);
		end
	end

	// a register-access level shuts itself off until software re-enables
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rawEn_q <= vxi_irq_pkg::RST_RAWEN;
			sigEn_q <= vxi_irq_pkg::RST_SIGEN;
		end else if (ce) begin
			if (wbWr && adr == vxi_irq_pkg::ADDR_RAWEN) begin
				rawEn_q <= datWr[6:0];
			end else if (state_q == vxi_irq_pkg::ST_IACK && iackDone && auto_q
				&& |(curBit & rora_q & route_q)) begin
				rawEn_q <= rawEn_q & ~curBit;
			end
			if (wbWr && adr == vxi_irq_pkg::ADDR_SIGEN) begin
				sigEn_q <= datWr[6:0];
			end else if (state_q == vxi_irq_pkg::ST_IACK && iackDone && auto_q
				&& |(curBit & rora_q & ~route_q)) begin
				sigEn_q <= sigEn_q & ~curBit;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < vxi_irq_pkg::NLA; i++) begin
				latab_q[i] <= vxi_irq_pkg::RST_LATAB;
			end
		end else if (ce && wbWr && adr == vxi_irq_pkg::ADDR_LATAB) begin
			latab_q[datWr[7:0]] <= datWr[vxi_irq_pkg::F_TAB +: 3];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// level selection: full queue masks the signal path

	assign pend = irqIn & ((route_q & rawEn_q)
		| (~route_q & sigEn_q & {7{~qFull}}));

	// highest level wins, mirroring backplane priority
	always_comb begin
		pick = 3'h0;
		for (int i = 0; i < vxi_irq_pkg::NLEV; i++) begin
			if (pend[i]) begin
				pick = 3'(i + 1);
			end
		end
	end

	assign curBit = levelBit(curLevel_q);
	assign tab    = latab_q[capt_q[7:0]];
	assign dispatch = capt_q[vxi_irq_pkg::EVENT_BIT] ? tab[vxi_irq_pkg::TAB_DEVT]
		: tab[vxi_irq_pkg::TAB_DRESP];
	assign qPush  = state_q == vxi_irq_pkg::ST_ROUTE && !(|(curBit & route_q))
		&& !dispatch;
	assign qPop   = ce && wbWr && adr == vxi_irq_pkg::ADDR_QPOP;

	////////////////////////////////////////////////////////////////////////
	// acknowledge sequencer

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_q    <= vxi_irq_pkg::ST_IDLE;
			curLevel_q <= 3'h0;
			auto_q     <= 1'b0;
			iackReq    <= 1'b0;
			iackLevel  <= 3'h0;
			capt_q     <= 16'h0000;
		end else if (ce) begin
			case (state_q)
				vxi_irq_pkg::ST_IDLE: begin
					if (pick != 3'h0) begin
						curLevel_q <= pick;
						iackLevel  <= pick;
						auto_q     <= 1'b1;
						iackReq    <= 1'b1;
						state_q    <= vxi_irq_pkg::ST_IACK;
					end else if (manReq_q) begin
						curLevel_q <= manLevel_q;
						iackLevel  <= manLevel_q;
						auto_q     <= 1'b0;
						iackReq    <= 1'b1;
						state_q    <= vxi_irq_pkg::ST_IACK;
					end
				end
				vxi_irq_pkg::ST_IACK: begin
					if (iackDone) begin
						iackReq <= 1'b0;
						capt_q  <= iackData;
						state_q <= auto_q ? vxi_irq_pkg::ST_ROUTE
							: vxi_irq_pkg::ST_IDLE;
					end
				end
				vxi_irq_pkg::ST_ROUTE: state_q <= vxi_irq_pkg::ST_IDLE;
				default: state_q <= vxi_irq_pkg::ST_IDLE;
			endcase
		end
	end

	// manual acknowledge command and its result
	always_ff @(posedge clk) begin
		if (!nrst) begin
			manReq_q    <= 1'b0;
			manDone_q   <= 1'b0;
			manLevel_q  <= 3'h0;
			manStatus_q <= 16'h0000;
		end else if (ce) begin
			if (state_q == vxi_irq_pkg::ST_IACK && iackDone && !auto_q) begin
				manReq_q    <= 1'b0;
				manDone_q   <= 1'b1;
				manStatus_q <= iackData;
			end else if (wbWr && adr == vxi_irq_pkg::ADDR_MIACK
				&& !manReq_q && datWr[2:0] != 3'h0) begin
				manLevel_q <= datWr[2:0];
				manReq_q   <= 1'b1;
				manDone_q  <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// delivery to raw path, signal dispatch and queue results

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rawValid  <= 1'b0;
			rawLevel  <= 3'h0;
			rawStatus <= 16'h0000;
			rawNew_q  <= 1'b0;
			sigValid  <= 1'b0;
			sigData   <= 16'h0000;
			sigCause  <= 3'h0;
		end else if (ce) begin
			rawValid <= 1'b0;
			sigValid <= 1'b0;
			if (wbRd && adr == vxi_irq_pkg::ADDR_RAWEVT) begin
				rawNew_q <= 1'b0;
			end
			if (state_q == vxi_irq_pkg::ST_ROUTE) begin
				if (|(curBit & route_q)) begin
					rawValid  <= 1'b1;
					rawLevel  <= curLevel_q;
					rawStatus <= capt_q;
					rawNew_q  <= 1'b1;
				end else if (dispatch) begin
					sigValid <= 1'b1;
					sigData  <= capt_q;
					sigCause <= causeOf(capt_q, tab[vxi_irq_pkg::TAB_MSG]);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			popFound_q <= 1'b0;
			popDone_q  <= 1'b0;
			popData_q  <= 16'h0000;
			queueFull  <= 1'b0;
			queueEmpty <= 1'b1;
		end else if (ce) begin
			queueFull  <= qFull;
			queueEmpty <= qEmpty;
			if (qPop) begin
				popDone_q  <= 1'b1;
				popFound_q <= qFound;
				popData_q  <= qData;
			end
		end
	end

	signal_queue queue (
		.clk       (clk),
		.nrst      (nrst),
		.ce        (ce),
		.pushValid (qPush && ce),
		.pushData  (capt_q),
		.full      (qFull),
		.empty     (qEmpty),
		.popReq    (qPop),
		.matchLa   (datWr[vxi_irq_pkg::F_MLA]),
		.matchType (datWr[vxi_irq_pkg::F_MTYPE]),
		.popLa     (datWr[7:0]),
		.popType   (datWr[vxi_irq_pkg::F_TYPE]),
		.popFound  (qFound),
		.popData   (qData)
	);

	////////////////////////////////////////////////////////////////////////
	// local interrupter, releases itself on acknowledge of its level

	always_ff @(posedge clk) begin
		if (!nrst) begin
			irqOut       <= 7'h00;
			locLevel_q   <= 3'h0;
			locId_q      <= 16'h0000;
			localIdValid <= 1'b0;
			localIdOut   <= 16'h0000;
		end else if (ce) begin
			localIdValid <= 1'b0;
			if (bpIackSeen && |(levelBit(bpIackLevel) & irqOut)) begin
				localIdValid <= 1'b1;
				localIdOut   <= locId_q;
				irqOut       <= irqOut & ~levelBit(bpIackLevel);
			end else if (wbWr && adr == vxi_irq_pkg::ADDR_LOCAL) begin
				if (datWr[vxi_irq_pkg::F_RELEASE]) begin
					irqOut <= 7'h00;
				end else if (datWr[vxi_irq_pkg::F_ASSERT]) begin
					irqOut     <= levelBit(datWr[2:0]);
					locLevel_q <= datWr[2:0];
					locId_q    <= datWr[vxi_irq_pkg::F_ID +: 16];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	AST_ROUTE_RESET: assert property (@(posedge clk)
		$rose(nrst) |-> route_q == 7'h00)
		else $error("levels not routed to signals after reset");
	AST_IACK_HELD: assert property (@(posedge clk)
		disable iff (!nrst) (ce && iackReq && !iackDone) |=> iackReq)
		else $error("acknowledge request dropped before answer");
	AST_RAW_DELIVER: assert property (@(posedge clk)
		disable iff (!nrst)
		(ce && state_q == vxi_irq_pkg::ST_ROUTE && |(curBit & route_q))
		|=> rawValid && rawStatus == $past(capt_q))
		else $error("raw path did not get the untouched word");
	AST_DISPATCH: assert property (@(posedge clk)
		disable iff (!nrst)
		(ce && state_q == vxi_irq_pkg::ST_ROUTE && !(|(curBit & route_q))
		&& dispatch) |=> sigValid && !rawValid)
		else $error("dispatched signal not delivered");
	// only the enable of the path the level is routed to gates it
	AST_RORA_OFF: assert property (@(posedge clk)
		disable iff (!nrst)
		(ce && state_q == vxi_irq_pkg::ST_IACK && iackDone && auto_q
		&& |(curBit & rora_q) && !wbWr)
		|=> !(|(curBit & ((route_q & rawEn_q) | (~route_q & sigEn_q)))))
		else $error("register-access level stayed enabled");
	AST_FULL_GATE: assert property (@(posedge clk)
		disable iff (!nrst) qFull |-> (pend & ~route_q) == 7'h00)
		else $error("signal level pending while queue full");
	AST_LOCAL_ROAK: assert property (@(posedge clk)
		disable iff (!nrst)
		(ce && bpIackSeen && |(levelBit(bpIackLevel) & irqOut))
		|=> localIdValid && localIdOut == locId_q)
		else $error("local interrupter gave no word on acknowledge");
	AST_MANUAL_DONE: assert property (@(posedge clk)
		disable iff (!nrst)
		(ce && state_q == vxi_irq_pkg::ST_IACK && iackDone && !auto_q)
		|=> manDone_q && manStatus_q == $past(iackData))
		else $error("manual acknowledge result lost");
	AST_SPLIT: assert property (@(posedge clk)
		disable iff (!nrst)
		(sigValid && sigCause == vxi_irq_pkg::CAUSE_RESPONSE)
		|-> !sigData[vxi_irq_pkg::EVENT_BIT])
		else $error("event word classed as response");

	COV_RAW:   cover property (@(posedge clk) disable iff (!nrst) rawValid);
	COV_SIG:   cover property (@(posedge clk) disable iff (!nrst) sigValid);
	COV_FULL:  cover property (@(posedge clk) disable iff (!nrst) qFull);
	COV_LOCAL: cover property (@(posedge clk) disable iff (!nrst)
		localIdValid);

endmodule

// file: vxi_interrupter_model.sv
// behavioural backplane interrupters facing the router's acknowledge link
module vxi_interrupter_model (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        fire,
	input  wire logic [2:0]  fireLvl,
	input  wire logic [15:0] fireWord,
	input  wire logic        fireRora,
	input  wire logic        clrRora,
	input  wire logic        slow,
	input  wire logic        iackReq,
	input  wire logic [2:0]  iackLevel,
	output logic      [6:0]  irqIn,
	output logic             iackDone,
	output logic      [15:0] iackData
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] word_q [7];
	logic [6:0]  rora_q;
	logic [3:0]  wait_q;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!nrst) begin
			irqIn <= 7'h00;
			rora_q <= 7'h00;
			iackDone <= 1'b0;
			iackData <= 16'h0000;
			wait_q <= 4'h0;
		end else begin
			if (fire) begin
				irqIn[fireLvl - 1] <= 1'b1;
				word_q[fireLvl - 1] <= fireWord;
				rora_q[fireLvl - 1] <= fireRora;
			end
			// device-specific access frees register-access lines
			if (clrRora)
				irqIn <= irqIn & ~rora_q;
			if (iackReq && !iackDone) begin
				// slow answers stretch the link, no fixed latency assumed
				if (wait_q < (slow ? 4'h5 : 4'h0))
					wait_q <= wait_q + 4'h1;
				else begin
					iackDone <= 1'b1;
					iackData <= word_q[iackLevel - 1];
					wait_q <= 4'h0;
					// release on acknowledge, except register-access lines
					if (!rora_q[iackLevel - 1])
						irqIn[iackLevel - 1] <= 1'b0;
				end
			end else if (!iackReq && iackDone) begin
				iackDone <= 1'b0;
				// released bus must not keep showing the answer
				iackData <= ~iackData;
			end
		end
	end
endmodule

// file: vxi_interrupt_signal_router_test.sv
// self-checking bench of the interrupt signal router
module vxi_interrupt_signal_router_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        ack, iackReq, iackDone, localIdValid, rawValid, sigValid;
	logic        queueFull, queueEmpty, bpIackSeen = 1'b0, fire = 1'b0;
	logic        fireRora = 1'b0, clrRora = 1'b0, slow = 1'b0, ce = 1'b1;
	logic [7:0]  adr = 8'h00;
	logic [31:0] datWr = 32'h0, datRd, rd;
	logic [6:0]  irqIn, irqOut;
	logic [2:0]  iackLevel, rawLevel, sigCause, fireLvl = 3'h1;
	logic [2:0]  bpIackLevel = 3'h0;
	logic [15:0] iackData, localIdOut, rawStatus, sigData, w;
	logic [15:0] fireWord = 16'h0;
	int          error_cnt = 0, n_tests = 0;
	logic [15:0] words [8] = '{
		{vxi_irq_pkg::CODE_NOCAUSE, 8'h05}, {vxi_irq_pkg::CODE_REQT, 8'h05},
		{vxi_irq_pkg::CODE_REQF, 8'h05}, {vxi_irq_pkg::CODE_UNRCMD, 8'h05},
		{vxi_irq_pkg::CODE_SHMEM, 8'h05}, 16'h8005, 16'h2305, 16'hc706};
	vxi_irq_pkg::cause_t causes [8] = '{
		vxi_irq_pkg::CAUSE_NOCAUSE, vxi_irq_pkg::CAUSE_REQT,
		vxi_irq_pkg::CAUSE_REQF, vxi_irq_pkg::CAUSE_UNRCMD,
		vxi_irq_pkg::CAUSE_SHMEM, vxi_irq_pkg::CAUSE_OTHER,
		vxi_irq_pkg::CAUSE_RESPONSE, vxi_irq_pkg::CAUSE_DEVDEP};
	////////////////////////////////////////////////////////////////////////
	vxi_interrupt_signal_router vxi_interrupt_signal_router_inst (
		.clk, .ce, .nrst, .cyc, .stb, .we, .adr, .sel(4'hf), .datWr,
		.datRd, .ack, .irqIn, .iackReq, .iackLevel, .iackDone, .iackData,
		.irqOut, .bpIackSeen, .bpIackLevel, .localIdValid, .localIdOut,
		.rawValid, .rawLevel, .rawStatus, .sigValid, .sigData, .sigCause,
		.queueFull, .queueEmpty);
	vxi_interrupter_model vxi_interrupter_model_inst (
		.clk, .nrst, .fire, .fireLvl, .fireWord, .fireRora, .clrRora, .slow,
		.iackReq, .iackLevel, .irqIn, .iackDone, .iackData);
	initial begin
		forever #20 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic wb(input logic w_, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w_;
		adr <= a;
		datWr <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			print_verdict();
		end
		r = datRd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	function automatic logic pick(int k);
		case (k)
			0: return rawValid;
			1: return sigValid;
			2: return irqIn == 7'h00;
			default: return localIdValid;
		endcase
	endfunction
	task automatic waitp(input int k);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pick(k) !== 1'b1 && n < 100);
		if (n >= 100) begin
			error_cnt++;
			print_verdict();
		end
	endtask
	task automatic shoot(input logic [2:0] l, input logic [15:0] d,
			input logic r);
		@(posedge clk);
		fire <= 1'b1;
		fireLvl <= l;
		fireWord <= d;
		fireRora <= r;
		slow <= 1'($urandom_range(1));
		@(posedge clk);
		fire <= 1'b0;
	endtask
	// a masked level must not start an acknowledge
	task automatic quiet();
		logic seen;
		seen = 1'b0;
		repeat (16) begin
			@(posedge clk);
			seen |= iackReq;
		end
		chk(seen, 0);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h4cdb6caf));
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		wb(0, vxi_irq_pkg::ADDR_ROUTE, 0, rd);
		chk(rd[6:0], vxi_irq_pkg::RST_ROUTE);
		wb(0, vxi_irq_pkg::ADDR_STAT, 0, rd);
		chk(rd[2:0], 3'h6);
		wb(0, 8'hfc, 0, rd);
		chk(rd, 0);
		wb(1, vxi_irq_pkg::ADDR_ROUTE, 32'h7f, rd);
		wb(1, vxi_irq_pkg::ADDR_RAWEN, 32'h7f, rd);
		for (int l = 1; l <= 7; l++) begin
			w = 16'($urandom);
			shoot(3'(l), w, 1'b0);
			waitp(0);
			chk(rawLevel, l);
			chk(rawStatus, w);
			chk(irqIn[l - 1], 0);
		end
		wb(0, vxi_irq_pkg::ADDR_RAWEVT, 0, rd);
		chk({rd[31:16], rd[8], rd[2:0]}, {w, 4'hf});
		// register-access level fires once, then stays off
		wb(1, vxi_irq_pkg::ADDR_ROUTE, 32'h27f, rd);
		shoot(3'h2, 16'h4a02, 1'b1);
		waitp(0);
		chk(rawLevel, 2);
		wb(0, vxi_irq_pkg::ADDR_RAWEN, 0, rd);
		chk(rd[6:0], 7'h7d);
		quiet();
		@(posedge clk);
		clrRora <= 1'b1;
		@(posedge clk);
		clrRora <= 1'b0;
		// raw enable alone must not serve a signal-routed level
		wb(1, vxi_irq_pkg::ADDR_ROUTE, 0, rd);
		wb(1, vxi_irq_pkg::ADDR_RAWEN, 32'h7f, rd);
		w = 16'($urandom);
		shoot(3'h4, w, 1'b0);
		quiet();
		wb(1, vxi_irq_pkg::ADDR_MIACK, 32'h4, rd);
		rd = 32'h0;
		for (int i = 0; i < 20 && rd[0] !== 1'b1; i++)
			wb(0, vxi_irq_pkg::ADDR_MIACK, 0, rd);
		chk({rd[31:16], rd[6:4], rd[0]}, {w, 3'h4, 1'b1});
		wb(1, vxi_irq_pkg::ADDR_SIGEN, 32'h7f, rd);
		wb(1, vxi_irq_pkg::ADDR_LATAB, 32'h705, rd);
		wb(1, vxi_irq_pkg::ADDR_LATAB, 32'h306, rd);
		for (int i = 0; i < 8; i++) begin
			shoot(3'($urandom_range(7, 1)), words[i], 1'b0);
			waitp(1);
			chk(sigData, words[i]);
			chk(sigCause, causes[i]);
		end
		// queue: fill, refuse, selective pop, ordered drain
		for (int i = 0; i < 8; i++) begin
			shoot(3'h3, {8'hfd, 4'h1, 4'(i)}, 1'b0);
			waitp(2);
		end
		repeat (4) @(posedge clk);
		chk(queueFull, 1);
		shoot(3'h3, 16'hfd18, 1'b0);
		quiet();
		wb(1, vxi_irq_pkg::ADDR_QPOP, 32'h113, rd);
		wb(0, vxi_irq_pkg::ADDR_QPOP, 0, rd);
		chk({rd[31:16], rd[0]}, {16'hfd13, 1'b1});
		waitp(2);
		repeat (4) @(posedge clk);
		for (int i = 0; i < 9; i++) begin
			wb(1, vxi_irq_pkg::ADDR_QPOP, 32'h600, rd);
			wb(0, vxi_irq_pkg::ADDR_QPOP, 0, rd);
			chk(rd[0], i < 8);
			if (i < 8)
				chk(rd[31:16], {8'hfd, 4'h1, 4'(i + (i > 2))});
		end
		chk(queueEmpty, 1);
		w = 16'($urandom);
		wb(1, vxi_irq_pkg::ADDR_LOCAL, {w, 16'h0105}, rd);
		@(posedge clk);
		chk(irqOut, 7'h10);
		wb(0, vxi_irq_pkg::ADDR_LOCAL, 0, rd);
		chk(rd, {w, 6'h0, 7'h10, 3'h5});
		bpIackSeen <= 1'b1;
		bpIackLevel <= 3'h5;
		@(posedge clk);
		bpIackSeen <= 1'b0;
		waitp(3);
		chk(localIdOut, w);
		@(posedge clk);
		chk(irqOut, 0);
		wb(1, vxi_irq_pkg::ADDR_LOCAL, 32'h107, rd);
		@(posedge clk);
		chk(irqOut, 7'h40);
		wb(1, vxi_irq_pkg::ADDR_LOCAL, 32'h200, rd);
		@(posedge clk);
		chk(irqOut, 0);
		// frozen clock enable: a pending line must wait for it
		ce <= 1'b0;
		shoot(3'h1, 16'h2321, 1'b0);
		quiet();
		ce <= 1'b1;
		waitp(2);
		repeat (4) @(posedge clk);
		chk(queueEmpty, 0);
		print_verdict();
	end
endmodule
